//--- common/cg_map.vh
// register map, fields, encodings and timing constants of the clock generator
// Functional notes
// RULE1: reset in internal engaged; PLL/low-power unreachable from it
// RULE2: software enables external source before mode
// RULE3: engaged external: set divider, clear internal select
// RULE4: bypassed external: clear internal select, source %10
// RULE5: bypassed FLL stays powered and locks
// RULE6: software waits for oscillator initialized flag
// RULE7: software checks reference status clear, lock set
// RULE8: software checks reference, lock, source status %10
// RULE9: FLL factor from range and optimize bits
// RULE10: software waits for lock after factor change
// RULE11: divide-by-32 acts only in FLL external modes; the code also applies it in LPE when the loop select is clear
// RULE12: software selects internal source, polls status %01
// RULE13: software avoids optimize bit with internal reference
// RULE14: software polls status after each select change
// RULE15: range writes ignored when low power or PLL
// RULE16: software sets divider and reference before loop select
// RULE17: output frequency terms chosen per mode
// RULE18: FLL reference 31.25 to 39.0625 kHz
// RULE19: PLL reference 1 to 2 MHz
// RULE20: bus clock is output divided by two
// RULE21: internal reference runs when its enable set
// RULE22: unavailable source keeps previous; status shows actual
`ifndef CG_MAP_VH
`define CG_MAP_VH

`define CG_OFS_CTRL_ONE     8'h00
`define CG_OFS_CTRL_TWO     8'h04
`define CG_OFS_CTRL_THREE   8'h08
`define CG_OFS_STATUS       8'h0C
`define CG_OFS_TEST_MULT    8'h10

`define CG_RST_CTRL_ONE     8'h04
`define CG_RST_CTRL_TWO     8'h40
`define CG_RST_CTRL_THREE   8'h01
`define CG_RST_TEST_MULT    8'h01

`define CG_CLOCK_SOURCE_SELECT_HI          7
`define CG_CLOCK_SOURCE_SELECT_LO          6
`define CG_REFERENCE_DIVIDER_HI          5
`define CG_REFERENCE_DIVIDER_LO          3
`define CG_INTERNAL_REFERENCE_SELECT_BIT        2
`define CG_BUS_DIVIDER_HI          7
`define CG_BUS_DIVIDER_LO          6
`define CG_RANGE_BIT        5
`define CG_LP_BIT           3
`define CG_EXTERNAL_OSCILLATOR_REQUEST_BIT        2
`define CG_EXTERNAL_REFERENCE_ENABLE_BIT      1
`define CG_INTERNAL_REFERENCE_ENABLE_BIT      0
`define CG_LOOP_SELECT_BIT         6
`define CG_DIVIDE_BY_32_BIT_BIT        4
`define CG_VCO_MULTIPLIER_HI          3
`define CG_VCO_MULTIPLIER_LO          0
`define CG_OPTIMIZE_32K_BIT_BIT        5
`define CG_DRS_BIT          0

`define CG_SRC_FLL          2'b00
`define CG_SRC_INT          2'b01
`define CG_SRC_EXT          2'b10
`define CG_SRC_PLL          2'b11

`define CG_FACTOR_512       11'h200
`define CG_FACTOR_608       11'h260
`define CG_FACTOR_1024      11'h400
`define CG_FACTOR_1216      11'h4C0
`define CG_DIVIDE_BY_32_BIT_LOG2       5'h05

`define CG_CLK_MHZ          25
`define CG_LOCK_NS          1000
`define CG_OSC_NS           2000

`endif

//--- core/cg_settle_timer.v
// settle counter: raises done a fixed number of cycles after it starts running
`timescale 1ns/10ps
`default_nettype none
module cg_settle_timer
(
	input  wire       clk,
	input  wire       resetn,
	input  wire       ce,
	input  wire       run,
	input  wire       restart,
	input  wire [7:0] limit,
	output reg        done_ff
);
	reg [7:0] cnt_ff;

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_ff  <= 8'h00;
			done_ff <= 1'b0;
		end
		else if (ce)
		begin
			if (restart || !run)
			begin
				cnt_ff  <= 8'h00;
				done_ff <= 1'b0;
			end
			else if (cnt_ff == limit)
				done_ff <= 1'b1;
			else
				cnt_ff <= cnt_ff + 8'h01;
		end
	end
endmodule
`default_nettype wire

//--- core/cg_top.v
// clock generator mode control with APB register access
`timescale 1ns/10ps
`default_nettype none
`include "cg_map.vh"
module cg_top
(
	input  wire        clk,
	input  wire        resetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata_ff,
	output reg         pready_ff,
	output reg         pslverr_ff,
	input  wire        ext_ref_present,
	output reg  [7:0]  mode_ff,
	output reg  [1:0]  clk_source_ff,
	output reg  [10:0] fll_factor_ff,
	output reg  [4:0]  ref_div_log2_ff,
	output reg  [3:0]  vco_multiplier_ff,
	output reg  [1:0]  out_div_log2_ff,
	output reg  [2:0]  bus_div_log2_ff,
	output reg         loop_on_ff,
	output reg         int_ref_on_ff,
	output reg         ext_ref_on_ff
);
	// one-hot mode codes
	localparam [7:0] M_FEI  = 8'h01;
	localparam [7:0] M_FEE  = 8'h02;
	localparam [7:0] M_FBE  = 8'h04;
	localparam [7:0] M_FBI  = 8'h08;
	localparam [7:0] M_PEE  = 8'h10;
	localparam [7:0] M_PBE  = 8'h20;
	localparam [7:0] M_LPI  = 8'h40;
	localparam [7:0] M_LPE  = 8'h80;
	// least times round up to whole cycles
	localparam [31:0] LOCK_CYC_N = (`CG_LOCK_NS * `CG_CLK_MHZ + 999) / 1000;
	localparam [31:0] OSC_CYC_N  = (`CG_OSC_NS * `CG_CLK_MHZ + 999) / 1000;
	localparam [7:0]  LOCK_CYC   = LOCK_CYC_N[7:0];
	localparam [7:0]  OSC_CYC    = OSC_CYC_N[7:0];

	reg  [7:0]  ctrl_one_ff;
	reg  [7:0]  ctrl_two_ff;
	reg  [7:0]  ctrl_three_ff;
	reg  [7:0]  test_mult_ff;
	reg         irefst_ff;
	reg         loop_status_ff;
	reg  [1:0]  clock_source_status_ff;
	reg  [15:0] cfg_ff;
	reg         ext_meta_ff;
	reg         ext_sync_ff;
	reg  [1:0]  nxt_clock_source_status;
	reg         nxt_irefst;
	reg  [7:0]  nxt_mode;
	reg  [10:0] nxt_factor;
	reg         src_ok;
	reg  [31:0] nxt_rdata;
	reg         nxt_err;
	wire        lock;
	wire        oscillator_initialized;
	wire        wr_en;
	wire        rd_setup;
	wire        ext_ok;
	wire        lp_eff;
	wire        divide_by_32_bit_eff;
	wire        loop_run;
	wire [15:0] nxt_cfg;
	wire [1:0]  clock_source_select;
	wire [1:0]  req_src;

	assign wr_en    = psel & penable & pwrite & pready_ff;
	assign rd_setup = psel & ~penable;
	assign clock_source_select     = ctrl_one_ff[`CG_CLOCK_SOURCE_SELECT_HI:`CG_CLOCK_SOURCE_SELECT_LO];

	// pin synchroniser
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ext_meta_ff <= 1'b0;
			ext_sync_ff <= 1'b0;
		end
		else if (ce)
		begin
			ext_meta_ff <= ext_ref_present;
			ext_sync_ff <= ext_meta_ff;
		end
	end

	// crystal start-up runs only while requested and used
	cg_settle_timer u_osc
	(
		.clk     (clk),
		.resetn  (resetn),
		.ce      (ce),
		.run     (ctrl_two_ff[`CG_EXTERNAL_OSCILLATOR_REQUEST_BIT] & ext_sync_ff &
		          (ctrl_two_ff[`CG_EXTERNAL_REFERENCE_ENABLE_BIT] | ~ctrl_one_ff[`CG_INTERNAL_REFERENCE_SELECT_BIT])),
		.restart (1'b0),
		.limit   (OSC_CYC),
		.done_ff (oscillator_initialized)
	);

	// a plain external clock needs no start-up, a crystal does
	assign ext_ok = ctrl_two_ff[`CG_EXTERNAL_OSCILLATOR_REQUEST_BIT] ? oscillator_initialized : ext_sync_ff;

	assign lp_eff    = ctrl_two_ff[`CG_LP_BIT] & (clock_source_status_ff != `CG_SRC_FLL);
	assign divide_by_32_bit_eff = ctrl_three_ff[`CG_DIVIDE_BY_32_BIT_BIT] & ctrl_two_ff[`CG_RANGE_BIT] &
	                   ~irefst_ff & ~loop_status_ff; // [RULE11]
	assign loop_run  = ~lp_eff & (irefst_ff | ext_ok); // [RULE5]
	assign nxt_cfg   = {irefst_ff, loop_status_ff, divide_by_32_bit_eff, ctrl_one_ff[`CG_REFERENCE_DIVIDER_HI:`CG_REFERENCE_DIVIDER_LO],
	                    ctrl_three_ff[`CG_VCO_MULTIPLIER_HI:`CG_VCO_MULTIPLIER_LO], test_mult_ff[`CG_OPTIMIZE_32K_BIT_BIT],
	                    test_mult_ff[`CG_DRS_BIT], lp_eff, 3'h0};

	// lock drops and restarts on any change the loop sees
	cg_settle_timer u_lock
	(
		.clk     (clk),
		.resetn  (resetn),
		.ce      (ce),
		.run     (loop_run),
		.restart (nxt_cfg != cfg_ff),
		.limit   (LOCK_CYC),
		.done_ff (lock)
	);

	assign req_src = (clock_source_select == `CG_SRC_FLL && loop_status_ff) ? `CG_SRC_PLL : clock_source_select;

	// source switching; status shows the source really in use
	always @*
	begin
		nxt_irefst = irefst_ff;
		if (ctrl_one_ff[`CG_INTERNAL_REFERENCE_SELECT_BIT])
			nxt_irefst = 1'b1;
		else if (ext_ok)
			nxt_irefst = 1'b0;
		case (req_src)
			`CG_SRC_INT: src_ok = 1'b1;
			`CG_SRC_EXT: src_ok = ext_ok;
			`CG_SRC_PLL: src_ok = ext_ok & ~irefst_ff & loop_status_ff; // [RULE22]
			default:     src_ok = irefst_ff | ext_ok;
		endcase
		nxt_clock_source_status = src_ok ? req_src : clock_source_status_ff; // [RULE22]
	end

	// mode decode from live status
	always @*
	begin
		case (clock_source_status_ff)
			`CG_SRC_FLL: nxt_mode = irefst_ff ? M_FEI : M_FEE;
			`CG_SRC_PLL: nxt_mode = M_PEE;
			`CG_SRC_INT: nxt_mode = lp_eff ? M_LPI : M_FBI;
			default:     nxt_mode = lp_eff ? M_LPE : (loop_status_ff ? M_PBE : M_FBE);
		endcase
	end

	// FLL factor from range and optimize bits
	always @*
	begin
		case ({test_mult_ff[`CG_OPTIMIZE_32K_BIT_BIT], test_mult_ff[`CG_DRS_BIT]})
			2'b00:   nxt_factor = `CG_FACTOR_512;
			2'b01:   nxt_factor = `CG_FACTOR_1024;
			2'b10:   nxt_factor = `CG_FACTOR_608;
			default: nxt_factor = `CG_FACTOR_1216;
		endcase // [RULE9]
	end

	// read mux, prepared in the setup cycle
	always @*
	begin
		nxt_rdata = 32'h0000_0000;
		nxt_err   = 1'b0;
		case (paddr)
			`CG_OFS_CTRL_ONE:   nxt_rdata = {24'h00_0000, ctrl_one_ff};
			`CG_OFS_CTRL_TWO:   nxt_rdata = {24'h00_0000, ctrl_two_ff};
			`CG_OFS_CTRL_THREE: nxt_rdata = {24'h00_0000, ctrl_three_ff};
			`CG_OFS_STATUS:     nxt_rdata = {24'h00_0000, 1'b0, lock, loop_status_ff, irefst_ff,
			                                 clock_source_status_ff, oscillator_initialized, 1'b0};
			`CG_OFS_TEST_MULT:  nxt_rdata = {24'h00_0000, test_mult_ff};
			default:            nxt_err   = 1'b1;
		endcase
	end

	// bus slave: one wait-free access phase after setup
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end
		else if (ce)
		begin
			pready_ff  <= rd_setup;
			pslverr_ff <= rd_setup & nxt_err;
			prdata_ff  <= (rd_setup & ~pwrite) ? nxt_rdata : 32'h0000_0000;
		end
	end

	// software registers and status
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_one_ff   <= `CG_RST_CTRL_ONE; // [RULE1]
			ctrl_two_ff   <= `CG_RST_CTRL_TWO;
			ctrl_three_ff <= `CG_RST_CTRL_THREE;
			test_mult_ff  <= `CG_RST_TEST_MULT;
			irefst_ff     <= 1'b1;
			loop_status_ff      <= 1'b0;
			clock_source_status_ff      <= `CG_SRC_FLL;
			cfg_ff        <= 16'h0000;
		end
		else if (ce)
		begin
			cfg_ff    <= nxt_cfg;
			irefst_ff <= nxt_irefst;
			loop_status_ff  <= ctrl_three_ff[`CG_LOOP_SELECT_BIT];
			clock_source_status_ff  <= nxt_clock_source_status;
			if (wr_en && paddr == `CG_OFS_CTRL_ONE)
				ctrl_one_ff <= pwdata[7:0];
			if (wr_en && paddr == `CG_OFS_CTRL_TWO)
			begin
				ctrl_two_ff <= pwdata[7:0];
				// low power cannot be entered straight from reset mode
				if (mode_ff == M_FEI)
					ctrl_two_ff[`CG_LP_BIT] <= ctrl_two_ff[`CG_LP_BIT]; // [RULE1]
			end
			if (wr_en && paddr == `CG_OFS_CTRL_THREE)
			begin
				ctrl_three_ff <= pwdata[7:0];
				// PLL select cannot be set straight from reset mode
				if (mode_ff == M_FEI)
					ctrl_three_ff[`CG_LOOP_SELECT_BIT] <= ctrl_three_ff[`CG_LOOP_SELECT_BIT]; // [RULE1]
			end
			if (wr_en && paddr == `CG_OFS_TEST_MULT)
			begin
				test_mult_ff[`CG_OPTIMIZE_32K_BIT_BIT] <= pwdata[`CG_OPTIMIZE_32K_BIT_BIT];
				if (!ctrl_two_ff[`CG_LP_BIT] && !ctrl_three_ff[`CG_LOOP_SELECT_BIT])
					test_mult_ff[`CG_DRS_BIT] <= pwdata[`CG_DRS_BIT]; // [RULE15]
			end
		end
	end

	// clock path settings per mode
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_ff           <= M_FEI;
			clk_source_ff     <= `CG_SRC_FLL;
			fll_factor_ff     <= `CG_FACTOR_1024;
			ref_div_log2_ff   <= 5'h00;
			vco_multiplier_ff <= 4'h0;
			out_div_log2_ff   <= 2'h1;
			bus_div_log2_ff   <= 3'h2;
			loop_on_ff        <= 1'b1;
			int_ref_on_ff     <= 1'b1;
			ext_ref_on_ff     <= 1'b0;
		end
		else if (ce)
		begin
			mode_ff           <= nxt_mode;
			clk_source_ff     <= clock_source_status_ff; // [RULE17]
			fll_factor_ff     <= nxt_factor;
			ref_div_log2_ff   <= {2'h0, ctrl_one_ff[`CG_REFERENCE_DIVIDER_HI:`CG_REFERENCE_DIVIDER_LO]} +
			                     (divide_by_32_bit_eff ? `CG_DIVIDE_BY_32_BIT_LOG2 : 5'h00); // [RULE11] [RULE17]
			vco_multiplier_ff <= ctrl_three_ff[`CG_VCO_MULTIPLIER_HI:`CG_VCO_MULTIPLIER_LO];
			out_div_log2_ff   <= ctrl_two_ff[`CG_BUS_DIVIDER_HI:`CG_BUS_DIVIDER_LO];
			bus_div_log2_ff   <= {1'b0, ctrl_two_ff[`CG_BUS_DIVIDER_HI:`CG_BUS_DIVIDER_LO]} + 3'h1; // [RULE20]
			loop_on_ff        <= ~lp_eff; // [RULE5]
			// internal reference may sleep in external modes to save power
			int_ref_on_ff     <= ctrl_two_ff[`CG_INTERNAL_REFERENCE_ENABLE_BIT] | irefst_ff |
			                     (clock_source_status_ff == `CG_SRC_INT); // [RULE21]
			ext_ref_on_ff     <= ctrl_two_ff[`CG_EXTERNAL_REFERENCE_ENABLE_BIT] | ~ctrl_one_ff[`CG_INTERNAL_REFERENCE_SELECT_BIT];
		end
	end
endmodule
`default_nettype wire

//--- verification/cg_ext_source.sv
// external reference source model feeding the presence pin
`timescale 1ns/10ps
`default_nettype none
module cg_ext_source
#(
	parameter int START_CYCLES = 4
)
(
	input  wire logic clk,
	input  wire logic enable,
	output var logic  present
);
	int cnt_ff;
	initial
	begin
		cnt_ff = 0;
		present = 1'b0;
	end
	// a stopped source reads absent, never its last level
	always @(posedge clk)
	begin
		cnt_ff <= enable ? cnt_ff + 1 : 0;
		present <= enable && (cnt_ff >= START_CYCLES);
	end
endmodule
`default_nettype wire

//--- verification/cg_top_sva.sv
// port checker for the clock generator mode control
`timescale 1ns/10ps
`default_nettype none
module cg_top_chk
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        ext_ref_present,
	input wire logic [31:0] prdata_ff,
	input wire logic        pready_ff,
	input wire logic        pslverr_ff,
	input wire logic [7:0]  mode_ff,
	input wire logic [1:0]  clk_source_ff,
	input wire logic [10:0] fll_factor_ff,
	input wire logic [1:0]  out_div_log2_ff,
	input wire logic [2:0]  bus_div_log2_ff,
	input wire logic        loop_on_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence ext_gone;
		(!ext_ref_present)[*6];
	endsequence
	sequence src_moves;
		clk_source_ff != $past(clk_source_ff);
	endsequence
	AST_RESET_MODE: assert property ($rose(resetn) |-> mode_ff == 8'h01)
		else $error("mode after reset is not internal engaged");
	AST_FEI_EXITS: assert property (mode_ff != $past(mode_ff) && $past(mode_ff) == 8'h01 |->
		mode_ff inside {8'h02, 8'h04, 8'h08})
		else $error("illegal mode left reset mode");
	AST_BUS_DIV: assert property (bus_div_log2_ff == {1'b0, out_div_log2_ff} + 3'd1)
		else $error("bus divider not output divider plus one");
	AST_FACTOR: assert property (fll_factor_ff inside {11'h200, 11'h260, 11'h400, 11'h4C0})
		else $error("fll factor outside legal set");
	AST_ABSENT_SRC: assert property (ext_gone ##1 src_moves |-> !clk_source_ff[1])
		else $error("absent external source became selected");
	AST_FBE_LOOP: assert property (mode_ff == 8'h04 |-> loop_on_ff)
		else $error("loop off in bypassed external mode");
	AST_APB_READY: assert property (psel && !penable && ce |=> pready_ff)
		else $error("no ready in cycle after setup");
	AST_ERR_PAIR: assert property (pslverr_ff |-> pready_ff)
		else $error("error without ready");
	AST_RDATA_IDLE: assert property (!pready_ff |-> prdata_ff == 32'h0000_0000)
		else $error("read data outside access cycle");
endmodule
bind cg_top cg_top_chk i_chk (.clk, .resetn, .ce, .psel, .penable, .ext_ref_present,
	.prdata_ff, .pready_ff, .pslverr_ff, .mode_ff, .clk_source_ff, .fll_factor_ff,
	.out_div_log2_ff, .bus_div_log2_ff, .loop_on_ff);
`default_nettype wire

//--- verification/clock_generator_mode_init_test.sv
// self-checking bench for the clock generator mode control
`timescale 1ns/10ps
`default_nettype none
`include "cg_map.vh"
module clock_generator_mode_init_test;
	logic        clk;
	logic        resetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        ext_en;
	logic        ce;
	wire  [31:0] prdata_ff;
	wire         pready_ff;
	wire         pslverr_ff;
	wire         ext_ref_present;
	wire  [7:0]  mode_ff;
	wire  [1:0]  clk_source_ff;
	wire  [10:0] fll_factor_ff;
	wire  [4:0]  ref_div_log2_ff;
	wire  [1:0]  out_div_log2_ff;
	wire  [2:0]  bus_div_log2_ff;
	wire  [3:0]  vco_multiplier_ff;
	wire         loop_on_ff;
	wire         int_ref_on_ff;
	wire         ext_ref_on_ff;
	int          mismatches = 0;
	int          check_count = 0;
	int          fact [4] = '{512, 1024, 608, 1216};
	logic [7:0]  mdl [0:4];
	logic [31:0] rd;
	logic        err;
	bit          fll_engaged_internal_mode = 1;
	cg_top i_dut
	(
		.clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
		.pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .ext_ref_present(ext_ref_present),
		.mode_ff(mode_ff), .clk_source_ff(clk_source_ff), .fll_factor_ff(fll_factor_ff),
		.ref_div_log2_ff(ref_div_log2_ff), .vco_multiplier_ff(vco_multiplier_ff),
		.out_div_log2_ff(out_div_log2_ff), .bus_div_log2_ff(bus_div_log2_ff),
		.loop_on_ff(loop_on_ff), .int_ref_on_ff(int_ref_on_ff), .ext_ref_on_ff(ext_ref_on_ff)
	);
	cg_ext_source #(.START_CYCLES(4)) i_src (.clk(clk), .enable(ext_en), .present(ext_ref_present));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready_ff !== 1'b1)
			@(posedge clk);
		rd = prdata_ff;
		err = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (fll_engaged_internal_mode && a == `CG_OFS_CTRL_TWO) v[`CG_LP_BIT] = mdl[1][`CG_LP_BIT];
		if (fll_engaged_internal_mode && a == `CG_OFS_CTRL_THREE) v[`CG_LOOP_SELECT_BIT] = mdl[2][`CG_LOOP_SELECT_BIT];
		if (a == `CG_OFS_TEST_MULT && (mdl[1][`CG_LP_BIT] || mdl[2][`CG_LOOP_SELECT_BIT]))
			v[`CG_DRS_BIT] = mdl[4][`CG_DRS_BIT];
		mdl[a[4:2]] = v;
		apb(1'b1, a, {24'h00_0000, d});
	endtask
	task automatic rdchk(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, {24'h00_0000, mdl[a[4:2]]}, "register");
	endtask
	task automatic poll(input logic [7:0] m, input logic [7:0] v);
		int n = 0;
		do
		begin
			apb(1'b0, `CG_OFS_STATUS, 32'h0000_0000);
			n++;
		end
		while ((rd[7:0] & m) !== v && n < 200);
		chk({24'h00_0000, rd[7:0] & m}, {24'h00_0000, v}, "status");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude();
	end
	initial
	begin
		{psel, penable, pwrite, ext_en, resetn} = 5'h00;
		ce = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		mdl = '{`CG_RST_CTRL_ONE, `CG_RST_CTRL_TWO, `CG_RST_CTRL_THREE, 8'h00, `CG_RST_TEST_MULT};
		void'($urandom(32'h7e1b));
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 5; i++)
			if (i != 3) rdchk(8'(i * 4));
		poll(8'h10, 8'h10);
		chk({31'h0, int_ref_on_ff}, 32'h0000_0001, "int ref on");
		chk({31'h0, ext_ref_on_ff}, 32'h0000_0000, "ext ref on");
		apb(1'b1, 8'h14 + 8'($urandom % 59) * 8'h04, $urandom);
		chk({31'h0, err}, 32'h1, "unmapped write");
		apb(1'b0, 8'h14 + 8'($urandom % 59) * 8'h04, 32'h0000_0000);
		chk({31'h0, err}, 32'h1, "unmapped read");
		chk(rd, 32'h0000_0000, "unmapped data");
		// low power and pll select must not stick from reset mode
		wr(`CG_OFS_CTRL_TWO, 8'h48);
		wr(`CG_OFS_CTRL_THREE, 8'h41);
		rdchk(`CG_OFS_CTRL_TWO);
		rdchk(`CG_OFS_CTRL_THREE);
		chk({24'h00_0000, mode_ff}, 32'h0000_0001, "mode");
		// internal bypass, then an absent external source must not be taken
		wr(`CG_OFS_CTRL_ONE, 8'h44);
		poll(8'h0C, 8'h04);
		chk({24'h00_0000, mode_ff}, 32'h0000_0008, "mode");
		wr(`CG_OFS_CTRL_ONE, 8'h84);
		repeat (8) @(posedge clk);
		poll(8'h0C, 8'h04);
		chk({30'h0, clk_source_ff}, 32'h0000_0001, "source");
		wr(`CG_OFS_CTRL_ONE, `CG_RST_CTRL_ONE);
		poll(8'h0C, 8'h00);
		chk({24'h00_0000, mode_ff}, 32'h0000_0001, "mode");
		ext_en <= 1'b1;
		wr(`CG_OFS_CTRL_TWO, 8'h26);
		poll(8'h02, 8'h02);
		wr(`CG_OFS_CTRL_THREE, 8'h11);
		wr(`CG_OFS_CTRL_ONE, 8'h18);
		fll_engaged_internal_mode = 0;
		poll(8'h5C, 8'h40);
		chk({24'h00_0000, mode_ff}, 32'h0000_0002, "mode");
		wr(`CG_OFS_CTRL_ONE, 8'h98);
		poll(8'h5C, 8'h48);
		chk({24'h00_0000, mode_ff}, 32'h0000_0004, "mode");
		chk({27'h0, ref_div_log2_ff}, 32'h0000_0008, "ref div");
		chk({29'h0, bus_div_log2_ff}, 32'h0000_0001, "bus div");
		chk({31'h0, int_ref_on_ff}, 32'h0000_0000, "int ref on");
		chk({31'h0, ext_ref_on_ff}, 32'h0000_0001, "ext ref on");
		chk({31'h0, loop_on_ff}, 32'h0000_0001, "loop on");
		// factor sweep kept to the external reference, as advised
		for (int i = 0; i < 4; i++)
		begin
			wr(`CG_OFS_TEST_MULT, {2'b00, i[1], 4'h0, i[0]});
			// first change with the clock enable low: lock must not advance
			if (i == 0)
			begin
				ce <= 1'b0;
				repeat (40) @(posedge clk);
				ce <= 1'b1;
				apb(1'b0, `CG_OFS_STATUS, 32'h0000_0000);
				chk({31'h0, rd[6]}, 32'h0000_0000, "lock while frozen");
			end
			poll(8'h40, 8'h40);
			chk({21'h0, fll_factor_ff}, 32'(fact[i]), "factor");
		end
		wr(`CG_OFS_CTRL_TWO, 8'h2E);
		wr(`CG_OFS_TEST_MULT, 8'h20);
		rdchk(`CG_OFS_TEST_MULT);
		chk({24'h00_0000, mode_ff}, 32'h0000_0080, "mode");
		wr(`CG_OFS_CTRL_ONE, 8'hD8);
		poll(8'h0C, 8'h08);
		chk({30'h0, clk_source_ff}, 32'h0000_0002, "source");
		// loop reference prepared before the loop select moves
		wr(`CG_OFS_CTRL_ONE, 8'h98);
		wr(`CG_OFS_CTRL_THREE, 8'h58);
		wr(`CG_OFS_CTRL_TWO, 8'h27);
		poll(8'h6C, 8'h68);
		chk({24'h00_0000, mode_ff}, 32'h0000_0020, "mode");
		chk({27'h0, ref_div_log2_ff}, 32'h0000_0003, "ref div");
		chk({28'h0, vco_multiplier_ff}, 32'h0000_0008, "vco");
		chk({31'h0, int_ref_on_ff}, 32'h0000_0001, "int ref on");
		wr(`CG_OFS_CTRL_ONE, 8'h18);
		poll(8'h0C, 8'h0C);
		chk({24'h00_0000, mode_ff}, 32'h0000_0010, "mode");
		chk({30'h0, clk_source_ff}, 32'h0000_0003, "source");
		conclude();
	end
endmodule
`default_nettype wire
